/* inc/gkwd_params.svh */
`ifndef GKWD_PARAMS_SVH
`define GKWD_PARAMS_SVH

// I/O port addresses of the index/data pair
`define GKWD_INDEX_PORT 16'h0024
`define GKWD_DATA_PORT 16'h0026

// Indexed register numbers
`define GKWD_IDX_GP_CTRL 16'h0007
`define GKWD_IDX_FUNC_SEL 16'h0111

// Field positions
`define GKWD_GP_DIR_BIT 15
`define GKWD_GP_LEVEL_BIT 11
`define GKWD_FSEL_WD_BIT 15

// Reset values
`define GKWD_GP_CTRL_RESET 16'h0000
`define GKWD_FUNC_SEL_RESET 16'h8000
`define GKWD_INDEX_RESET 16'h0000

// Timing
`define GKWD_CLK_HZ 10000000
`define GKWD_LONG_TIMEOUT_MS 1600
`define GKWD_SHORT_TIMEOUT_MS 100
`define GKWD_PULSE_NS 1600
`define GKWD_LONG_CYCLES (`GKWD_LONG_TIMEOUT_MS * (`GKWD_CLK_HZ / 1000))
`define GKWD_SHORT_CYCLES (`GKWD_SHORT_TIMEOUT_MS * (`GKWD_CLK_HZ / 1000))
`define GKWD_PULSE_CYCLES ((`GKWD_PULSE_NS * (`GKWD_CLK_HZ / 1000000)) / 1000)

`endif

/* inc/gkwd_pkg.sv */
package gkwd_pkg;

    typedef enum logic [2:0] {
        GKWD_IDLE = 3'b001,
        GKWD_COUNT = 3'b010,
        GKWD_FIRE = 3'b100
    } gkwd_fsm_t;

    typedef logic [15:0] gkwd_word_t;

endpackage

/* hw/gkwd_sync.sv */
module gkwd_sync
    import gkwd_pkg::*;
#(
    parameter int unsigned WIDTH = 1
) (
    input wire logic REF_CLK, // System clock
    input wire logic NRST, // Asynchronous reset, active low
    input wire logic [WIDTH-1:0] ASYNC_IN, // Levels from pins
    output logic [WIDTH-1:0] LEVEL // Filtered synchronous levels
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] level;
    } gkwd_sync_state_t;

    gkwd_sync_state_t st;
    gkwd_sync_state_t next_st;

    generate
        if (WIDTH < 1) begin : g_check
            $error("gkwd_sync: WIDTH must be at least 1");
        end
    endgenerate

    always_comb begin
        next_st = st;
        next_st.s1 = ASYNC_IN;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        // A change counts only once the second and third stages agree
        next_st.level = (st.s2 & st.s3) | (st.level & (st.s2 ^ st.s3));
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign LEVEL = st.level;

endmodule // gkwd_sync

/* hw/gkwd_top.sv */
`include "gkwd_params.svh"

// Functional notes
// - Any reset leaves the watchdog disarmed so no timeout can happen until software arms it.
// - An armed watchdog that sees no refresh toggle within the timeout emits a processor reset pulse.
// - The watchdog can only be active while the permit strap is asserted.
// - Indexed registers are reached by writing the index port and then accessing the 16-bit data port.
// - Clearing bit 15 of the pin function select register hands the refresh pin to general-purpose control.
// - Setting bit 15 of the general-purpose control register makes the refresh pin an output and arms the watchdog.
// - Bit 11 of the general-purpose control register drives the refresh pin level, flipped by software.
// - Clearing bit 15 of the general-purpose control register disarms the watchdog.
// - With the timeout-select strap in its default state the timeout is 1.6 seconds.
// - A board strap selects a short timeout of 100 ms instead.
module gkwd_top
    import gkwd_pkg::*;
#(
    parameter int unsigned LONG_CYCLES = `GKWD_LONG_CYCLES,
    parameter int unsigned SHORT_CYCLES = `GKWD_SHORT_CYCLES,
    parameter int unsigned PULSE_CYCLES = `GKWD_PULSE_CYCLES,
    parameter int unsigned CNT_W = 25
) (
    input wire logic REF_CLK, // System clock, 10 MHz
    input wire logic NRST, // Asynchronous reset, active low
    input wire logic [15:0] IO_ADDR, // I/O port address
    input wire logic [15:0] IO_WDATA, // I/O write data
    input wire logic IO_WR, // I/O write strobe, one cycle
    input wire logic IO_RD, // I/O read strobe, one cycle
    output logic [15:0] IO_RDATA, // Registered read data
    output logic IO_RVALID, // Read data valid, one cycle
    input wire logic REFRESH_PIN_IN, // Level seen on the refresh pin
    output logic REFRESH_PIN_OUT, // Level driven on the refresh pin
    output logic REFRESH_PIN_OE, // High while the pin is driven
    input wire logic PERMIT_STRAP, // Board strap, high permits activation
    input wire logic SHORT_TIMEOUT_STRAP, // Board strap, high selects short timeout
    output logic WD_RESET_N, // Processor reset pulse, active low
    output logic WD_ARMED // Watchdog currently counting
);

    typedef struct packed {
        gkwd_word_t index;
        gkwd_word_t gp_ctrl;
        gkwd_word_t func_sel;
        gkwd_word_t rdata;
        logic rvalid;
        logic pin_prev;
        gkwd_fsm_t fsm;
        logic [CNT_W-1:0] cnt;
        logic [7:0] pulse_cnt;
    } gkwd_state_t;

    localparam logic [CNT_W-1:0] LONG_LAST = CNT_W'(LONG_CYCLES - 1);
    localparam logic [CNT_W-1:0] SHORT_LAST = CNT_W'(SHORT_CYCLES - 1);
    localparam logic [7:0] PULSE_LAST = 8'(PULSE_CYCLES - 1);

    gkwd_state_t st;
    gkwd_state_t next_st;
    logic [2:0] sync_level;
    logic pin_level;
    logic permit;
    logic short_sel;
    logic pin_gp;
    logic pin_drive;
    logic armed;
    logic kick;
    logic [CNT_W-1:0] last_cnt;
    gkwd_word_t window_rd;
    gkwd_word_t gp_rd;

    generate
        if (CNT_W > 32 || (64'(1) << CNT_W) <= 64'(LONG_CYCLES) || (64'(1) << CNT_W) <= 64'(SHORT_CYCLES)) begin : g_cnt
            $error("gkwd_top: CNT_W too small for the timeout counts");
        end
        if (LONG_CYCLES < 1 || SHORT_CYCLES < 1) begin : g_tmo
            $error("gkwd_top: timeout counts must be at least one cycle");
        end
        if (PULSE_CYCLES < 1 || PULSE_CYCLES > 256) begin : g_pls
            $error("gkwd_top: PULSE_CYCLES must lie in 1..256");
        end
    endgenerate

    // Straps and the pin level come from outside the clock domain
    gkwd_sync #(
        .WIDTH(3)
    ) u_sync (
        .REF_CLK(REF_CLK),
        .NRST(NRST),
        .ASYNC_IN({SHORT_TIMEOUT_STRAP, PERMIT_STRAP, REFRESH_PIN_IN}),
        .LEVEL(sync_level)
    );

    assign pin_level = sync_level[0];
    assign permit = sync_level[1];
    assign short_sel = sync_level[2];

    always_comb begin
        pin_gp = ~st.func_sel[`GKWD_FSEL_WD_BIT];
        pin_drive = pin_gp & st.gp_ctrl[`GKWD_GP_DIR_BIT];
        armed = pin_drive & permit;
        kick = pin_level ^ st.pin_prev;
        last_cnt = LONG_LAST;
        if (short_sel) begin
            last_cnt = SHORT_LAST;
        end
        // An input pin reads back its real level, an output its latch
        gp_rd = st.gp_ctrl;
        if (!pin_drive) begin
            gp_rd[`GKWD_GP_LEVEL_BIT] = pin_level;
        end
        case (st.index)
            `GKWD_IDX_GP_CTRL: begin
                window_rd = gp_rd;
            end
            `GKWD_IDX_FUNC_SEL: begin
                window_rd = st.func_sel;
            end
            default: begin
                window_rd = '0;
            end
        endcase
    end

    always_comb begin
        next_st = st;
        next_st.rvalid = 1'b0;
        next_st.pin_prev = pin_level;

        if (IO_WR) begin
            if (IO_ADDR == `GKWD_INDEX_PORT) begin
                next_st.index = IO_WDATA;
            end else if (IO_ADDR == `GKWD_DATA_PORT) begin
                case (st.index)
                    `GKWD_IDX_GP_CTRL: begin
                        next_st.gp_ctrl = IO_WDATA;
                    end
                    `GKWD_IDX_FUNC_SEL: begin
                        next_st.func_sel = IO_WDATA;
                    end
                    default: begin
                        next_st.gp_ctrl = st.gp_ctrl;
                    end
                endcase
            end
        end

        if (IO_RD) begin
            if (IO_ADDR == `GKWD_INDEX_PORT) begin
                next_st.rdata = st.index;
                next_st.rvalid = 1'b1;
            end else if (IO_ADDR == `GKWD_DATA_PORT) begin
                next_st.rdata = window_rd;
                next_st.rvalid = 1'b1;
            end
        end

        case (st.fsm)
            GKWD_IDLE: begin
                next_st.cnt = '0;
                next_st.pulse_cnt = '0;
                if (armed) begin
                    next_st.fsm = GKWD_COUNT;
                end
            end
            GKWD_COUNT: begin
                if (!armed) begin
                    next_st.fsm = GKWD_IDLE;
                    next_st.cnt = '0;
                end else if (kick) begin
                    next_st.cnt = '0;
                end else if (st.cnt >= last_cnt) begin
                    next_st.fsm = GKWD_FIRE;
                    next_st.pulse_cnt = '0;
                end else begin
                    next_st.cnt = st.cnt + CNT_W'(1);
                end
            end
            GKWD_FIRE: begin
                next_st.gp_ctrl[`GKWD_GP_DIR_BIT] = 1'b0;
                next_st.cnt = '0;
                if (st.pulse_cnt == PULSE_LAST) begin
                    next_st.fsm = GKWD_IDLE;
                end else begin
                    next_st.pulse_cnt = st.pulse_cnt + 8'h01;
                end
            end
            default: begin
                next_st.fsm = GKWD_IDLE;
                next_st.cnt = '0;
            end
        endcase
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            st.index <= `GKWD_INDEX_RESET;
            st.gp_ctrl <= `GKWD_GP_CTRL_RESET;
            st.func_sel <= `GKWD_FUNC_SEL_RESET;
            st.rdata <= '0;
            st.rvalid <= 1'b0;
            st.pin_prev <= 1'b0;
            st.fsm <= GKWD_IDLE;
            st.cnt <= '0;
            st.pulse_cnt <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign REFRESH_PIN_OUT = st.gp_ctrl[`GKWD_GP_LEVEL_BIT];
    assign REFRESH_PIN_OE = pin_drive;
    assign IO_RDATA = st.rdata;
    assign IO_RVALID = st.rvalid;
    assign WD_RESET_N = ~st.fsm[2];
    assign WD_ARMED = st.fsm[1];

endmodule // gkwd_top

/* sim/gkwd_checker.sv */
`include "gkwd_params.svh"
module gkwd_checker #(
    parameter int unsigned LONG_CYCLES = 200,
    parameter int unsigned SHORT_CYCLES = 50,
    parameter int unsigned PULSE_CYCLES = 16
) (
    input wire logic REF_CLK, // System clock
    input wire logic NRST, // Reset, active low
    input wire logic [15:0] IO_ADDR, // Port address
    input wire logic [15:0] IO_WDATA, // Write data
    input wire logic IO_WR, // Write strobe
    input wire logic IO_RD, // Read strobe
    input wire logic [15:0] IO_RDATA, // Read data
    input wire logic IO_RVALID, // Read data valid
    input wire logic REFRESH_PIN_IN, // Pin wire level
    input wire logic REFRESH_PIN_OUT, // Pin driven level
    input wire logic REFRESH_PIN_OE, // Pin driver enable
    input wire logic PERMIT_STRAP, // Permit strap
    input wire logic SHORT_TIMEOUT_STRAP, // Short timeout strap
    input wire logic WD_RESET_N, // Reset pulse, active low
    input wire logic WD_ARMED // Watchdog counting
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!NRST);
    // Wide enough for the full pulse and timeout counts
    logic [8:0] lo_cnt;
    logic [31:0] run_cnt;
    logic prev_pin;
    logic [31:0] lim;
    logic rd_hit;
    assign lim = SHORT_TIMEOUT_STRAP ? SHORT_CYCLES : LONG_CYCLES;
    assign rd_hit = IO_RD && (IO_ADDR == `GKWD_INDEX_PORT || IO_ADDR == `GKWD_DATA_PORT);
    // Quiet time counted from the wire, so an internal kick slip shows
    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            lo_cnt <= 9'h000;
            run_cnt <= 32'h0000_0000;
            prev_pin <= 1'b0;
        end else begin
            lo_cnt <= WD_RESET_N ? 9'h000 : lo_cnt + 9'h001;
            run_cnt <= (!WD_ARMED || REFRESH_PIN_IN != prev_pin) ? 32'h0000_0000 : run_cnt + 32'h0000_0001;
            prev_pin <= REFRESH_PIN_IN;
        end
    end
    sequence s_fire;
        $fell(WD_RESET_N);
    endsequence
    sequence s_rd;
        rd_hit;
    endsequence
    a_reset_idle: assert property ($rose(NRST) |-> WD_RESET_N && !WD_ARMED)
        else $error("armed after reset");
    a_pulse_len: assert property ($rose(WD_RESET_N) |-> lo_cnt == PULSE_CYCLES)
        else $error("pulse length");
    a_pulse_bound: assert property (!WD_RESET_N |-> lo_cnt < PULSE_CYCLES)
        else $error("pulse too long");
    a_fire_window: assert property (s_fire |-> run_cnt >= lim - 2 && run_cnt <= lim + 8)
        else $error("timeout moment");
    a_late_fire: assert property (WD_ARMED |-> run_cnt <= lim + 8)
        else $error("timeout missed");
    a_fire_disarms: assert property (s_fire |-> ##2 !REFRESH_PIN_OE && !WD_ARMED)
        else $error("still armed after pulse");
    a_oe_disarm: assert property (!REFRESH_PIN_OE |=> !WD_ARMED)
        else $error("armed without output");
    a_permit_low: assert property (!PERMIT_STRAP [*6] |=> !WD_ARMED)
        else $error("armed without permit");
    a_rd_answer: assert property (s_rd |=> IO_RVALID)
        else $error("no read answer");
    a_rvalid_cause: assert property (!rd_hit |=> !IO_RVALID)
        else $error("stray read answer");
endmodule // gkwd_checker
bind gkwd_top gkwd_checker #(.LONG_CYCLES(LONG_CYCLES), .SHORT_CYCLES(SHORT_CYCLES), .PULSE_CYCLES(PULSE_CYCLES))
    i_gkwd_checker (.REF_CLK, .NRST, .IO_ADDR, .IO_WDATA, .IO_WR, .IO_RD, .IO_RDATA, .IO_RVALID, .REFRESH_PIN_IN,
    .REFRESH_PIN_OUT, .REFRESH_PIN_OE, .PERMIT_STRAP, .SHORT_TIMEOUT_STRAP, .WD_RESET_N, .WD_ARMED);

/* sim/tb_top.sv */
`include "gkwd_params.svh"
module tb_top import gkwd_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int LC = 200;
    localparam int SC = 50;
    logic REF_CLK = 0, NRST = 0, IO_WR = 0, IO_RD = 0, PERMIT_STRAP = 1, SHORT_TIMEOUT_STRAP = 0, ext_lvl = 0;
    logic [15:0] IO_ADDR = 0, IO_WDATA = 0, IO_RDATA;
    logic IO_RVALID, REFRESH_PIN_OUT, REFRESH_PIN_OE, WD_RESET_N, WD_ARMED;
    int n_fail = 0, num_checks = 0, n;
    gkwd_word_t gp;
    // Wire level resolved from the driver enable
    wire REFRESH_PIN_IN = REFRESH_PIN_OE ? REFRESH_PIN_OUT : ext_lvl;
    gkwd_top #(.LONG_CYCLES(LC), .SHORT_CYCLES(SC)) i_gkwd_top (.REF_CLK, .NRST, .IO_ADDR, .IO_WDATA, .IO_WR,
        .IO_RD, .IO_RDATA, .IO_RVALID, .REFRESH_PIN_IN, .REFRESH_PIN_OUT, .REFRESH_PIN_OE, .PERMIT_STRAP,
        .SHORT_TIMEOUT_STRAP, .WD_RESET_N, .WD_ARMED);
    initial forever #50 REF_CLK = ~REF_CLK;
    task finish_test;
        if (n_fail == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        if (got !== exp) begin
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
            n_fail++;
        end
        num_checks++;
    endtask
    task io(input logic [15:0] a, input logic [15:0] d, input logic w);
        @(negedge REF_CLK);
        IO_ADDR = a; IO_WDATA = d; IO_WR = w; IO_RD = !w;
        @(negedge REF_CLK);
        IO_WR = 0; IO_RD = 0;
    endtask
    task rd(input logic [15:0] a, input logic [15:0] exp, input logic v);
        io(a, 16'h0000, 0);
        chk(IO_RVALID, v);
        if (v) chk(IO_RDATA, exp);
    endtask
    task reg_wr(input logic [15:0] i, input logic [15:0] d);
        io(`GKWD_INDEX_PORT, i, 1);
        io(`GKWD_DATA_PORT, d, 1);
    endtask
    task reg_rd(input logic [15:0] i, input logic [15:0] exp);
        io(`GKWD_INDEX_PORT, i, 1);
        rd(`GKWD_DATA_PORT, exp, 1);
    endtask
    // Time to the pulse must fall in a window, then the pulse width is exact
    task fire(input int lo, input int hi);
        n = 0;
        while (WD_RESET_N === 1'b1 && n < 600) begin @(negedge REF_CLK); n++; end
        chk(n >= lo && n <= hi, 1);
        n = 0;
        while (WD_RESET_N === 1'b0 && n < 40) begin @(negedge REF_CLK); n++; end
        chk(16'(n), `GKWD_PULSE_CYCLES);
    endtask
    initial begin
        #2_000_000;
        n_fail++;
        finish_test;
    end
    initial begin
        repeat (3) @(negedge REF_CLK);
        NRST = 1;
        chk(WD_ARMED, 0);
        reg_rd(16'h0007, 16'h0000);
        reg_rd(16'h0111, 16'h8000);
        rd(`GKWD_INDEX_PORT, 16'h0111, 1);
        io(16'h0025, 16'h1234, 1);
        rd(16'h0028, 16'h0000, 0);
        reg_rd(16'h0123, 16'h0000);
        // A window write under an unknown index must touch neither register
        io(`GKWD_DATA_PORT, 16'hffff, 1);
        reg_rd(16'h0007, 16'h0000);
        reg_rd(16'h0111, 16'h8000);
        reg_wr(16'h0007, 16'h8000);
        chk(REFRESH_PIN_OE, 0);
        reg_wr(16'h0111, 16'h0000);
        chk(REFRESH_PIN_OE, 1);
        gp = 16'h8000;
        for (int k = 0; k < 4; k++) begin
            repeat (120) @(negedge REF_CLK);
            gp ^= 16'h0800;
            reg_wr(16'h0007, gp);
            chk(REFRESH_PIN_OUT, gp[11]);
        end
        chk({WD_ARMED, WD_RESET_N}, 2'b11);
        reg_rd(16'h0007, gp);
        fire(LC - 6, LC + 8);
        reg_rd(16'h0007, 16'h0000);
        SHORT_TIMEOUT_STRAP = 1;
        repeat (8) @(negedge REF_CLK);
        reg_wr(16'h0007, 16'h8000);
        fire(SC - 2, SC + 8);
        reg_wr(16'h0007, 16'h8000);
        repeat (20) @(negedge REF_CLK);
        reg_wr(16'h0007, 16'h0000);
        repeat (150) @(negedge REF_CLK);
        chk({WD_ARMED, WD_RESET_N}, 2'b01);
        // A pin left as input reads back its own wire level
        ext_lvl = 1;
        repeat (6) @(negedge REF_CLK);
        reg_rd(16'h0007, 16'h0800);
        ext_lvl = 0;
        PERMIT_STRAP = 0;
        repeat (8) @(negedge REF_CLK);
        reg_wr(16'h0007, 16'h8000);
        repeat (150) @(negedge REF_CLK);
        chk({WD_ARMED, WD_RESET_N}, 2'b01);
        PERMIT_STRAP = 1;
        repeat (10) @(negedge REF_CLK);
        chk(WD_ARMED, 1);
        NRST = 0;
        @(negedge REF_CLK);
        chk(WD_ARMED, 0);
        NRST = 1;
        reg_rd(16'h0007, 16'h0000);
        reg_rd(16'h0111, 16'h8000);
        finish_test;
    end
endmodule // tb_top
